// File: sfm_core.sv
// flag set/clear and register copy execution unit behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sfm_regs.svh"
module sfm_core
  import sfm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`SFM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`SFM_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic [7:0] processorFlags
);

  logic awHave_q, wHave_q, bValid_q, rValid_q;
  logic [`SFM_ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rData_q;
  logic [3:0] wStrb_q;
  logic [1:0] bResp_q, rResp_q;
  logic [7:0] flags_q, flags_d;
  logic [7:0] gpr_q [`SFM_GPR_NUM];
  sfm_instr_t lastInstr_q;
  logic lastErr_q;

  // write channel: address and data are caught independently, in either order
  assign s_axi_awready = !awHave_q && !bValid_q;
  assign s_axi_wready = !wHave_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign processorFlags = flags_q;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire wrDo = awHave_q && wHave_q;
  wire arFire = s_axi_arvalid && s_axi_arready;

  wire wrIsExec = awAddr_q == `SFM_OFF_EXEC;
  wire wrIsFlags = awAddr_q == `SFM_OFF_FLAGS;
  wire wrIsGpr = awAddr_q >= `SFM_OFF_GPR;
  wire [`SFM_GPR_IDX_W-1:0] wrGprIdx = awAddr_q[`SFM_GPR_IDX_W+1:2];

  sfm_instr_t instr;
  assign instr = {wData_q[`SFM_EXEC_RR_LSB +: `SFM_GPR_IDX_W],
                  wData_q[`SFM_EXEC_RD_LSB +: `SFM_GPR_IDX_W],
                  wData_q[`SFM_EXEC_OP_LSB +: 4]};

  // a partial write of the instruction word would execute half an instruction
  wire execWrite = wrDo && wrIsExec && ((wStrb_q & `SFM_EXEC_STRB) == `SFM_EXEC_STRB);
  wire opLegal = instr.op <= `SFM_OP_COPY;
  wire execOk = execWrite && opLegal;
  wire execCopy = execOk && (instr.op == `SFM_OP_COPY);
  wire execFlagOp = execOk && (instr.op != `SFM_OP_COPY) && (instr.op != `SFM_OP_NOP);
  wire wrFlags = wrDo && wrIsFlags && wStrb_q[0];
  wire wrGpr = wrDo && wrIsGpr && wStrb_q[0];
  wire wrErr = wrDo && (!(wrIsExec || wrIsFlags || wrIsGpr) || (wrIsExec && !execOk));

  // one-hot mask and forced value of the flag an instruction touches
  logic [7:0] opMask;
  logic opVal;
  always_comb begin
    opMask = 8'h00;
    opVal = 1'b0;
    case (sfm_op_t'(instr.op))
      SFM_OP_IRQ_ON: begin
        opMask[`SFM_BIT_I] = 1'b1;
        opVal = 1'b1;
      end
      SFM_OP_IRQ_OFF: begin
        opMask[`SFM_BIT_I] = 1'b1;
      end
      SFM_OP_SET_S: begin
        opMask[`SFM_BIT_S] = 1'b1;
        opVal = 1'b1;
      end
      SFM_OP_CLR_S: begin
        opMask[`SFM_BIT_S] = 1'b1;
      end
      SFM_OP_SET_V: begin
        opMask[`SFM_BIT_V] = 1'b1;
        opVal = 1'b1;
      end
      SFM_OP_CLR_V: begin
        opMask[`SFM_BIT_V] = 1'b1;
      end
      SFM_OP_SET_H: begin
        opMask[`SFM_BIT_H] = 1'b1;
        opVal = 1'b1;
      end
      SFM_OP_CLR_H: begin
        opMask[`SFM_BIT_H] = 1'b1;
      end
      default: begin
        opMask = 8'h00;
        opVal = 1'b0;
      end
    endcase
  end

  // a flag instruction moves only the masked bit; a flags register write loads all 8; copy leaves flags alone
  assign flags_d = wrFlags ? wData_q[7:0] :
                   execFlagOp ? ((flags_q & ~opMask) | (opVal ? opMask : 8'h00)) :
                   flags_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) flags_q <= `SFM_FLAGS_RST;
    else flags_q <= flags_d;
  end

  wire [7:0] gprSrc = gpr_q[instr.rr];
  wire [7:0] gprWd = wrGpr ? wData_q[7:0] : gprSrc;

  genvar g;
  generate
    for (g = 0; g < `SFM_GPR_NUM; g++) begin : gen_gpr
      wire we = (wrGpr && wrGprIdx == g) || (execCopy && instr.rd == g);
      always_ff @(posedge ref_clk) begin
        if (sys_rst) gpr_q[g] <= `SFM_GPR_RST;
        else if (we) gpr_q[g] <= gprWd;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= `SFM_RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (awFire) begin
        awHave_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[`SFM_ADDR_W-1:2], 2'b00};
      end
      if (wFire) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= wrErr ? `SFM_RESP_SLVERR : `SFM_RESP_OKAY;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lastInstr_q <= '0;
      lastErr_q <= 1'b0;
    end else if (wrDo && wrIsExec) begin
      lastInstr_q <= instr;
      lastErr_q <= !execOk;
    end
  end

  // read side
  wire [`SFM_ADDR_W-1:0] rdAddr = {s_axi_araddr[`SFM_ADDR_W-1:2], 2'b00};
  wire rdIsExec = rdAddr == `SFM_OFF_EXEC;
  wire rdIsFlags = rdAddr == `SFM_OFF_FLAGS;
  wire rdIsGpr = rdAddr >= `SFM_OFF_GPR;
  wire [`SFM_GPR_IDX_W-1:0] rdGprIdx = rdAddr[`SFM_GPR_IDX_W+1:2];
  wire [31:0] execWord = {lastErr_q, 10'h000, lastInstr_q.rr[4:0], 3'h0, lastInstr_q.rd,
                          4'h0, lastInstr_q.op};
  wire [31:0] rdMux = rdIsExec ? execWord :
                      rdIsFlags ? {24'h00_0000, flags_q} :
                      rdIsGpr ? {24'h00_0000, gpr_q[rdGprIdx]} : 32'h0000_0000;
  wire rdErr = !(rdIsExec || rdIsFlags || rdIsGpr);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= `SFM_RESP_OKAY;
    end else if (arFire) begin
      rValid_q <= 1'b1;
      rData_q <= rdMux;
      rResp_q <= rdErr ? `SFM_RESP_SLVERR : `SFM_RESP_OKAY;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  wire opIs1 = instr.op == `SFM_OP_IRQ_ON;
  wire opIs2 = instr.op == `SFM_OP_IRQ_OFF;

  a_irq_on_flag: assert property (execOk && opIs1 |=> flags_q[`SFM_BIT_I])
    else $error("interrupt enable not set");
  a_irq_off_flag: assert property (execOk && opIs2 |=> !flags_q[`SFM_BIT_I])
    else $error("interrupt enable not cleared");
  a_sign_set: assert property (execOk && instr.op == `SFM_OP_SET_S |=>
    flags_q[`SFM_BIT_S]) else $error("sign test not set");
  a_sign_clear: assert property (execOk && instr.op == `SFM_OP_CLR_S |=>
    !flags_q[`SFM_BIT_S]) else $error("sign test not cleared");
  a_ovf_set: assert property (execOk && instr.op == `SFM_OP_SET_V |=>
    flags_q[`SFM_BIT_V]) else $error("overflow not set");
  a_ovf_clear: assert property (execOk && instr.op == `SFM_OP_CLR_V |=>
    !flags_q[`SFM_BIT_V]) else $error("overflow not cleared");
  a_half_set: assert property (execOk && instr.op == `SFM_OP_SET_H |=>
    flags_q[`SFM_BIT_H]) else $error("half carry not set");
  a_half_clear: assert property (execOk && instr.op == `SFM_OP_CLR_H |=>
    !flags_q[`SFM_BIT_H]) else $error("half carry not cleared");
  a_copy_data: assert property (execCopy |=> gpr_q[$past(instr.rd)] == $past(gprSrc))
    else $error("copy wrote wrong value");
  a_copy_flags: assert property (execCopy |=> $stable(flags_q))
    else $error("copy changed flags");
  a_flag_only_one: assert property (execFlagOp |=>
    ((flags_q ^ $past(flags_q)) & ~$past(opMask)) == 8'h00)
    else $error("flag instruction touched other bits");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_answer: assert property (wrDo |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response late");
  a_read_answer: assert property (arFire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");

  c_copy: cover property (execCopy);
  c_irq_on_then_off: cover property (execOk && opIs1 ##[1:20] execOk && opIs2);
  c_bad_addr: cover property (wrErr);
  c_read_flags: cover property (arFire && rdIsFlags);

endmodule
`default_nettype wire

// File: sfm_pkg.sv
// types shared by the flag/move unit
`default_nettype none
`include "sfm_regs.svh"
package sfm_pkg;

  typedef enum logic [3:0] {
    SFM_OP_NOP = `SFM_OP_NOP,
    SFM_OP_IRQ_ON = `SFM_OP_IRQ_ON,
    SFM_OP_IRQ_OFF = `SFM_OP_IRQ_OFF,
    SFM_OP_SET_S = `SFM_OP_SET_S,
    SFM_OP_CLR_S = `SFM_OP_CLR_S,
    SFM_OP_SET_V = `SFM_OP_SET_V,
    SFM_OP_CLR_V = `SFM_OP_CLR_V,
    SFM_OP_SET_H = `SFM_OP_SET_H,
    SFM_OP_CLR_H = `SFM_OP_CLR_H,
    SFM_OP_COPY = `SFM_OP_COPY
  } sfm_op_t;

  typedef struct packed {
    logic [`SFM_GPR_IDX_W-1:0] rr;
    logic [`SFM_GPR_IDX_W-1:0] rd;
    logic [3:0] op;
  } sfm_instr_t;

endpackage
`default_nettype wire

// File: sfm_regs.svh
// register offsets, field positions, encodings and reset values of the flag/move unit
// Operation
// - the interrupt-on instruction writes the global interrupt enable flag to 1.
// - the interrupt-off instruction writes the global interrupt enable flag to 0.
// - set-sign-test forces the signed test flag to 1.
// - clear-sign-test forces the signed test flag to 0.
// - set-overflow forces the two's-complement overflow flag to 1.
// - clear-overflow forces the two's-complement overflow flag to 0.
// - set-half-carry forces the half-carry flag to 1.
// - clear-half-carry forces the half-carry flag to 0.
// - copy-register writes source register into destination, flags untouched.
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH

`define SFM_ADDR_W 8
`define SFM_OFF_EXEC 8'h00
`define SFM_OFF_FLAGS 8'h04
`define SFM_OFF_GPR 8'h80
`define SFM_GPR_NUM 32
`define SFM_GPR_IDX_W 5

`define SFM_FLAGS_RST 8'h00
`define SFM_GPR_RST 8'h00

`define SFM_BIT_C 0
`define SFM_BIT_Z 1
`define SFM_BIT_N 2
`define SFM_BIT_V 3
`define SFM_BIT_S 4
`define SFM_BIT_H 5
`define SFM_BIT_T 6
`define SFM_BIT_I 7

`define SFM_EXEC_OP_LSB 0
`define SFM_EXEC_RD_LSB 8
`define SFM_EXEC_RR_LSB 16
`define SFM_EXEC_ERR_BIT 31
`define SFM_EXEC_STRB 4'h7

`define SFM_OP_NOP 4'h0
`define SFM_OP_IRQ_ON 4'h1
`define SFM_OP_IRQ_OFF 4'h2
`define SFM_OP_SET_S 4'h3
`define SFM_OP_CLR_S 4'h4
`define SFM_OP_SET_V 4'h5
`define SFM_OP_CLR_V 4'h6
`define SFM_OP_SET_H 4'h7
`define SFM_OP_CLR_H 4'h8
`define SFM_OP_COPY 4'h9

`define SFM_RESP_OKAY 2'h0
`define SFM_RESP_SLVERR 2'h2

`endif

// File: status_flag_and_move_ops_tb.sv
// self-checking bench for the flag set/clear and register copy unit
`timescale 1ns/1ps
`default_nettype none
`include "sfm_regs.svh"
module status_flag_and_move_ops_tb
  import sfm_pkg::*;
;
  logic refClk = 1'b0;
  logic sysRst = 1'b1;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00, flags;
  logic [31:0] wData = 32'h0000_0000, rData;
  logic [3:0] wStrb = 4'h0;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rd;
  logic [7:0] base, expFlags;
  int fails = 0, tests_run = 0;
  int bitPos [1:8] = '{7, 7, 4, 4, 3, 3, 5, 5};

  always #10 refClk = ~refClk;

  sfm_core dut (.ref_clk(refClk), .sys_rst(sysRst), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .processorFlags(flags));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // address and data offered together; bready and rready stay high between transfers
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit done;
    done = 0;
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge refClk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) begin
        done = 1;
        resp = bResp;
      end
    end
    if (!done) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    bit done;
    done = 0;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge refClk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid === 1'b1) begin
        done = 1;
        rd = rData;
        resp = rResp;
      end
    end
    if (!done) begin
      fails++;
      stop_test();
    end
  endtask

  function automatic logic [31:0] exec_word(input logic [3:0] op, input logic [4:0] dst,
      input logic [4:0] src);
    return {11'h000, src, 3'h0, dst, 4'h0, op};
  endfunction

  initial begin
    repeat (6) @(posedge refClk);
    sysRst <= 1'b0;
    @(posedge refClk);
    axi_read(`SFM_OFF_FLAGS);
    chk("flags after reset", 32'h0000_0000, rd);
    chk("flag port after reset", 32'h0000_0000, {24'h00_0000, flags});
    $display("test reset done");
    // each flag op from all-clear and all-set, so both the own bit and the others show
    for (int b = 0; b < 2; b++) begin
      base = b ? 8'hFF : 8'h00;
      for (int op = 1; op <= 8; op++) begin
        axi_write(`SFM_OFF_FLAGS, {24'h00_0000, base}, 4'hF);
        axi_write(`SFM_OFF_EXEC, exec_word(op[3:0], 5'h00, 5'h00), 4'hF);
        expFlags = op[0] ? base | (8'h01 << bitPos[op]) : base & ~(8'h01 << bitPos[op]);
        chk("flag op resp", 32'h0000_0000, {30'h0, resp});
        chk("flag port", 32'(expFlags), 32'(flags));
        axi_read(`SFM_OFF_FLAGS);
        chk("flags read resp", 32'h0000_0000, {30'h0, resp});
        chk("flags read", {24'h00_0000, expFlags}, rd);
      end
    end
    $display("test flag ops done");
    axi_write(`SFM_OFF_GPR + 8'h14, 32'h0000_00A5, 4'hF);
    axi_write(`SFM_OFF_GPR + 8'h0C, 32'h0000_003C, 4'hF);
    axi_write(`SFM_OFF_FLAGS, 32'h0000_005A, 4'hF);
    axi_write(`SFM_OFF_EXEC, exec_word(4'h9, 5'h03, 5'h05), 4'hF);
    chk("copy resp", 32'h0000_0000, {30'h0, resp});
    chk("flags after copy", 32'h0000_005A, {24'h00_0000, flags});
    axi_read(`SFM_OFF_GPR + 8'h0C);
    chk("copy destination", 32'h0000_00A5, rd);
    axi_read(`SFM_OFF_GPR + 8'h14);
    chk("copy source", 32'h0000_00A5, rd);
    axi_read(`SFM_OFF_EXEC);
    chk("exec readback", exec_word(4'h9, 5'h03, 5'h05), rd);
    $display("test copy done");
    // refused requests must leave the flags alone
    axi_write(`SFM_OFF_EXEC, exec_word(4'hA, 5'h00, 5'h00), 4'hF);
    chk("illegal op resp", 32'h0000_0002, {30'h0, resp});
    axi_write(`SFM_OFF_EXEC, exec_word(4'h1, 5'h00, 5'h00), 4'h3);
    chk("partial exec resp", 32'h0000_0002, {30'h0, resp});
    chk("flags after refusals", 32'h0000_005A, {24'h00_0000, flags});
    axi_read(`SFM_OFF_EXEC);
    chk("refused exec readback", 32'h8000_0001, rd);
    axi_write(8'h40, 32'h0000_00FF, 4'hF);
    chk("unmapped write resp", 32'h0000_0002, {30'h0, resp});
    axi_write(`SFM_OFF_EXEC, exec_word(4'h0, 5'h00, 5'h00), 4'hF);
    chk("nop resp", 32'h0000_0000, {30'h0, resp});
    chk("flags after nop", 32'h0000_005A, 32'(flags));
    axi_read(8'h40);
    chk("unmapped resp", 32'h0000_0002, {30'h0, resp});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test refusals done");
    stop_test();
  end
endmodule
`default_nettype wire
